// ==== core/ssf_pkg.sv ====
package ssf_pkg;
    localparam int          AXI_AW        = 8;
    localparam logic [7:0]  ADDR_STATUS   = 8'h94;
    localparam logic [7:0]  ADDR_CTRL     = 8'h98;
    localparam logic [7:0]  ADDR_OWN      = 8'h9c;
    localparam logic [7:0]  ADDR_BUF      = 8'ha0;
    localparam logic [7:0]  ADDR_ISTS     = 8'ha4;
    localparam logic [7:0]  ADDR_IMASK    = 8'ha8;
    localparam logic [7:0]  STATUS_RST    = 8'h00;
    localparam int          ST_SMP        = 7;
    localparam int          ST_CKE        = 6;
    localparam int          CT_EN         = 5;
    localparam int          CT_CKP        = 4;
    localparam int          CT_TEN        = 1;
    localparam int          CT_I2C        = 0;
    localparam int          IRQ_START     = 0;
    localparam int          IRQ_STOP      = 1;
    localparam int          IRQ_BYTE      = 2;
    localparam int          IRQ_W         = 3;
    localparam logic [4:0]  TEN_HDR       = 5'h1e;
    localparam logic [2:0]  BYTE_LAST     = 3'h7;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    typedef enum logic [1:0] {SSF_IDLE, SSF_SHIFT, SSF_ACK} ssf_state_t;
endpackage

// ==== core/ssf_status_flags.sv ====
// Overview of operation
// - SPI transmit edge is edge-select bit XOR idle polarity; set means rising.
// - Stop flag sets on stop, clears on later start, disable or reset.
// - Start flag sets on start, clears on later stop, disable or reset.
// - Read/write bit of last matching address is captured; one is read.
// - Ten-bit mode raises update-address flag until software reloads own address.
// - Port runs only while enabled; disabling clears start and stop flags.
// - Interrupt flag sets on start, stop and each byte received while matched or addressed.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module ssf_status_flags
    import ssf_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [AXI_AW-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [AXI_AW-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   spi_tx_rising,
    output logic                   irq
);
    logic              awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]       rdata_q, rdata_d, rd_val;
    logic              rd_hit, wr_hit, wr_go, rd_go;
    logic [7:0]        wa, ra;
    logic              scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic              start_det, stop_det, scl_rise, i2c_on;
    logic              smp_q, smp_d, cke_q, cke_d, da_q, da_d, stop_q, stop_d, start_q, start_d;
    logic              rw_q, rw_d, ua_q, ua_d, bf_q, bf_d;
    logic [7:0]        ctrl_q, ctrl_d, buf_q, buf_d, shreg_q, shreg_d, nb;
    logic [9:0]        own_q, own_d;
    logic [IRQ_W-1:0]  ists_q, ists_d, imask_q, imask_d, iclr;
    logic [2:0]        cnt_q, cnt_d;
    logic              first_q, first_d, ten_hi_q, ten_hi_d, addressed_q, addressed_d;
    logic              byte_rx, rw_load, ua_set, irq_q, irq_d, txr_q, txr_d;
    ssf_state_t        st_q, st_d;

    assign awready       = awready_q;
    assign wready        = awready_q;
    assign bvalid        = bvalid_q;
    assign bresp         = bresp_q;
    assign arready       = arready_q;
    assign rvalid        = rvalid_q;
    assign rdata         = rdata_q;
    assign rresp         = rresp_q;
    assign irq           = irq_q;
    assign spi_tx_rising = txr_q;

    // The handshake cycle is the one in which the ready flops are high.
    assign wa    = {awaddr[7:2], 2'b00};
    assign ra    = {araddr[7:2], 2'b00};
    assign wr_go = awready_q && awvalid && wvalid;
    assign rd_go = arready_q && arvalid;
    assign wr_hit = (wa == ADDR_STATUS) || (wa == ADDR_CTRL) || (wa == ADDR_OWN) ||
                    (wa == ADDR_BUF) || (wa == ADDR_ISTS) || (wa == ADDR_IMASK);

    always_comb
    begin
        rd_hit = 1'b1;
        case (ra)
            ADDR_STATUS: rd_val = 32'({smp_q, cke_q, da_q, stop_q, start_q, rw_q, ua_q, bf_q});
            ADDR_CTRL:   rd_val = 32'(ctrl_q);
            ADDR_OWN:    rd_val = 32'(own_q);
            ADDR_BUF:    rd_val = 32'(buf_q);
            ADDR_ISTS:   rd_val = 32'(ists_q);
            ADDR_IMASK:  rd_val = 32'(imask_q);
            default:
            begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        awready_d = awvalid && wvalid && !awready_q && !bvalid_q;
        arready_d = arvalid && !arready_q && !rvalid_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (wr_go)
        begin
            bvalid_d = 1'b1;
            bresp_d  = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
            bvalid_d = 1'b0;
        if (rd_go)
        begin
            rvalid_d = 1'b1;
            rdata_d  = rd_val;
            rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rready)
            rvalid_d = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end
        else
        begin
            awready_q <= awready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // Bus lines are asynchronous; the third stage only serves edge detection.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
        end
        else
        begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
        end
    end

    assign i2c_on    = ctrl_q[CT_EN] && ctrl_q[CT_I2C];
    assign start_det = i2c_on && scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    assign stop_det  = i2c_on && scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
    assign scl_rise  = i2c_on && scl_s_q && !scl_p_q;
    assign nb        = {shreg_q[6:0], sda_s_q};

    always_comb
    begin
        smp_d = smp_q; cke_d = cke_q; ctrl_d = ctrl_q; own_d = own_q; imask_d = imask_q;
        da_d = da_q; stop_d = stop_q; start_d = start_q; rw_d = rw_q; ua_d = ua_q; bf_d = bf_q;
        buf_d = buf_q; shreg_d = shreg_q; cnt_d = cnt_q; st_d = st_q;
        first_d = first_q; ten_hi_d = ten_hi_q; addressed_d = addressed_q;
        byte_rx = 1'b0; rw_load = 1'b0; ua_set = 1'b0; iclr = '0;
        if (wr_go && wstrb[0])
        begin
            // Software must leave these two clear while in I2C mode.
            if (wa == ADDR_STATUS)
            begin
                smp_d = wdata[ST_SMP];
                cke_d = wdata[ST_CKE];
            end
            if (wa == ADDR_CTRL)
                ctrl_d = wdata[7:0];
            if (wa == ADDR_OWN)
            begin
                own_d[7:0] = wdata[7:0];
                ua_d       = 1'b0;
            end
            if (wa == ADDR_ISTS)
                iclr = wdata[IRQ_W-1:0];
            if (wa == ADDR_IMASK)
                imask_d = wdata[IRQ_W-1:0];
        end
        if (wr_go && wstrb[1] && wa == ADDR_OWN)
            own_d[9:8] = wdata[9:8];
        if (rd_go && ra == ADDR_BUF)
            bf_d = 1'b0;
        case (st_q)
            SSF_IDLE: st_d = SSF_IDLE;
            SSF_SHIFT:
                if (scl_rise)
                begin
                    shreg_d = nb;
                    cnt_d   = cnt_q + 3'h1;
                    if (cnt_q == BYTE_LAST)
                    begin
                        st_d    = SSF_ACK;
                        first_d = 1'b0;
                        if (first_q && ctrl_q[CT_TEN])
                        begin
                            if (nb[7:3] == TEN_HDR && nb[2:1] == own_q[9:8])
                            begin
                                ten_hi_d    = !nb[0];
                                addressed_d = nb[0];
                                rw_load     = 1'b1;
                                ua_set      = 1'b1;
                            end
                        end
                        else if (first_q)
                        begin
                            if (nb[7:1] == own_q[6:0])
                            begin
                                addressed_d = 1'b1;
                                rw_load     = 1'b1;
                            end
                        end
                        else if (ten_hi_q)
                        begin
                            ten_hi_d = 1'b0;
                            if (nb == own_q[7:0])
                            begin
                                addressed_d = 1'b1;
                                ua_set      = 1'b1;
                                byte_rx     = 1'b1;
                                da_d        = 1'b0;
                            end
                        end
                        else if (addressed_q)
                        begin
                            byte_rx = 1'b1;
                            da_d    = 1'b1;
                        end
                        if (rw_load)
                        begin
                            rw_d    = nb[0];
                            da_d    = 1'b0;
                            byte_rx = 1'b1;
                        end
                    end
                end
            SSF_ACK:
                if (scl_rise)
                begin
                    st_d  = SSF_SHIFT;
                    cnt_d = 3'h0;
                end
            default: st_d = SSF_IDLE;
        endcase
        if (ua_set)
            ua_d = 1'b1;
        if (byte_rx)
        begin
            buf_d = nb;
            bf_d  = 1'b1;
        end
        if (start_det)
        begin
            st_d        = SSF_SHIFT;
            cnt_d       = 3'h0;
            first_d     = 1'b1;
            ten_hi_d    = 1'b0;
            addressed_d = 1'b0;
            start_d     = 1'b1;
            stop_d      = 1'b0;
        end
        if (stop_det)
        begin
            st_d        = SSF_IDLE;
            addressed_d = 1'b0;
            stop_d      = 1'b1;
            start_d     = 1'b0;
        end
        if (!ctrl_q[CT_EN])
        begin
            st_d    = SSF_IDLE;
            start_d = 1'b0;
            stop_d  = 1'b0;
        end
        // An event in the clearing cycle survives: set is applied after clear.
        ists_d = (ists_q & ~iclr) | {byte_rx, stop_det, start_det};
        irq_d  = |(ists_q & imask_q);
        txr_d  = cke_q ^ ctrl_q[CT_CKP];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {smp_q, cke_q, da_q, stop_q, start_q, rw_q, ua_q, bf_q} <= STATUS_RST;
            ctrl_q <= 8'h00; own_q <= 10'h000; buf_q <= 8'h00; shreg_q <= 8'h00;
            ists_q <= '0; imask_q <= '0; cnt_q <= 3'h0; st_q <= SSF_IDLE;
            first_q <= 1'b0; ten_hi_q <= 1'b0; addressed_q <= 1'b0; irq_q <= 1'b0; txr_q <= 1'b0;
        end
        else
        begin
            {smp_q, cke_q, da_q, stop_q, start_q, rw_q, ua_q, bf_q} <=
                {smp_d, cke_d, da_d, stop_d, start_d, rw_d, ua_d, bf_d};
            ctrl_q <= ctrl_d; own_q <= own_d; buf_q <= buf_d; shreg_q <= shreg_d;
            ists_q <= ists_d; imask_q <= imask_d; cnt_q <= cnt_d; st_q <= st_d;
            first_q <= first_d; ten_hi_q <= ten_hi_d; addressed_q <= addressed_d;
            irq_q <= irq_d; txr_q <= txr_d;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_edge_sel;
        1 |=> txr_q == ($past(cke_q) ^ $past(ctrl_q[CT_CKP]));
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("transmit edge select wrong");
    property p_stop_set;
        stop_det |=> stop_q && !start_q;
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop flag not set");
    property p_start_set;
        start_det |=> start_q && !stop_q && ists_q[IRQ_START];
    endproperty
    a_start_set: assert property (p_start_set) else $error("start flag not set");
    property p_rw_cap;
        rw_load |=> rw_q == $past(sda_s_q) && !da_q;
    endproperty
    a_rw_cap: assert property (p_rw_cap) else $error("direction bit not captured");
    property p_ua_set;
        ua_set |=> ua_q;
    endproperty
    a_ua_set: assert property (p_ua_set) else $error("update address flag not set");
    property p_disable;
        !ctrl_q[CT_EN] |=> !start_q && !stop_q && st_q == SSF_IDLE;
    endproperty
    a_disable: assert property (p_disable) else $error("disabled port kept flags");
    property p_irq;
        (byte_rx || stop_det) && imask_q[IRQ_BYTE] && imask_q[IRQ_STOP] |=> ##1 irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    property p_bf;
        byte_rx |=> bf_q && buf_q == $past(nb);
    endproperty
    a_bf: assert property (p_bf) else $error("buffer full not set");
    property p_bresp;
        wr_go |=> bvalid_q && !awready_q;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response missing");
endmodule
`default_nettype wire

// ==== verif/ssf_i2c_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module ssf_i2c_master
(
    output logic scl,
    output logic sda
);
    // Both lines rest high through the pull-up, and the clock stands still between frames.
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task start_c;
        #40 sda = 1'b1;
        #40 scl = 1'b1;
        #80 sda = 1'b0;
        #80 scl = 1'b0;
    endtask
    task stop_c;
        #40 sda = 1'b0;
        #40 scl = 1'b1;
        #80 sda = 1'b1;
    endtask
    // The ninth clock is the acknowledge slot; the line is released, so the pull-up shows a one.
    task byte_c(input logic [7:0] b);
        for (int i = 8; i >= 0; i--)
        begin
            sda = (i > 0) ? b[i-1] : 1'b1;
            #40 scl = 1'b1;
            #80 scl = 1'b0;
            #40;
        end
    endtask
endmodule
`default_nettype wire

// ==== verif/serial_port_status_flags_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module serial_port_status_flags_tb;
    import ssf_pkg::*;
    typedef struct packed { logic [31:0] d; logic [31:0] m; logic [1:0] r; } ssf_exp_t;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [AXI_AW-1:0] awaddr = '0;
    logic              awvalid = 1'b0;
    logic              awready;
    logic [31:0]       wdata = '0;
    logic [3:0]        wstrb = '0;
    logic              wvalid = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready = 1'b0;
    logic [AXI_AW-1:0] araddr = '0;
    logic              arvalid = 1'b0;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready = 1'b0;
    logic              scl;
    logic              sda;
    logic              spi_tx_rising;
    logic              irq;
    int                miscompares = 0;
    int                n_tests = 0;
    int                cyc = 0;
    integer            seed = 32'h798cb05d;
    logic [6:0]        own7;
    logic [9:0]        own10;
    logic [7:0]        dat;
    ssf_exp_t          rq[$];
    logic [1:0]        bq[$];
    always #5 aclk = ~aclk;
    ssf_i2c_master bus (.scl(scl), .sda(sda));
    ssf_status_flags uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_in(scl), .sda_in(sda),
        .spi_tx_rising(spi_tx_rising), .irq(irq));
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
        rq.push_back('{e, m, r});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    // Kinds: 0 start, 1 byte, 2 stop; the wait covers the synchroniser latency.
    task ev(input int k, input logic [7:0] b);
        if (k == 0)
            bus.start_c();
        else if (k == 1)
            bus.byte_c(b);
        else
            bus.stop_c();
        repeat (8) @(posedge aclk);
    endtask
    task irq_is(input logic e);
        repeat (3) @(posedge aclk);
        `CHK("irq", e, irq)
    endtask
    always @(posedge aclk)
    begin
        ssf_exp_t x;
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            x = rq.pop_front();
            `CHK("rdata", x.d & x.m, rdata & x.m)
            `CHK("rresp", x.r, rresp)
        end
        if (bvalid === 1'b1 && bready === 1'b1)
            `CHK("bresp", bq.pop_front(), bresp)
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    initial
    begin
        own7 = 7'($random(seed));
        own10 = 10'($random(seed));
        dat = 8'($random(seed));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_STATUS, {24'h0, STATUS_RST}, 32'hffffffff, RESP_OKAY);
        rd(ADDR_CTRL, 32'h0, 32'hffffffff, RESP_OKAY);
        wr(8'h00, 32'h1, 4'hf, RESP_SLVERR);
        rd(8'h00, 32'h0, 32'hffffffff, RESP_SLVERR);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CTRL, (32'h1 << CT_EN) | (32'(i[1]) << CT_CKP), 4'h1, RESP_OKAY);
            wr(ADDR_STATUS, (32'(i[1]) << ST_SMP) | (32'(i[0]) << ST_CKE), 4'h1, RESP_OKAY);
            rd(ADDR_STATUS, (32'(i[1]) << ST_SMP) | (32'(i[0]) << ST_CKE), 32'hff, RESP_OKAY);
            repeat (2) @(posedge aclk);
            `CHK("spi_tx_rising", i[0] ^ i[1], spi_tx_rising)
        end
        wr(ADDR_STATUS, 32'h0, 4'h1, RESP_OKAY);
        wr(ADDR_CTRL, 32'h21, 4'h1, RESP_OKAY);
        wr(ADDR_OWN, {25'h0, own7}, 4'h3, RESP_OKAY);
        ev(0, 8'h0);
        rd(ADDR_STATUS, 32'h08, 32'h1f, RESP_OKAY);
        ev(1, {own7, 1'b0});
        rd(ADDR_STATUS, 32'h09, 32'h2d, RESP_OKAY);
        rd(ADDR_BUF, {24'h0, own7, 1'b0}, 32'hff, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, 32'h01, RESP_OKAY);
        ev(1, dat);
        rd(ADDR_STATUS, 32'h21, 32'h21, RESP_OKAY);
        rd(ADDR_BUF, {24'h0, dat}, 32'hff, RESP_OKAY);
        ev(2, 8'h0);
        rd(ADDR_STATUS, 32'h10, 32'h18, RESP_OKAY);
        rd(ADDR_ISTS, 32'h7, 32'h7, RESP_OKAY);
        irq_is(1'b0);
        wr(ADDR_IMASK, 32'h2, 4'h1, RESP_OKAY);
        irq_is(1'b1);
        wr(ADDR_ISTS, 32'h2, 4'h1, RESP_OKAY);
        irq_is(1'b0);
        rd(ADDR_ISTS, 32'h5, 32'h7, RESP_OKAY);
        wr(ADDR_ISTS, 32'h5, 4'h1, RESP_OKAY);
        ev(0, 8'h0);
        rd(ADDR_STATUS, 32'h08, 32'h18, RESP_OKAY);
        ev(1, {own7, 1'b1});
        rd(ADDR_STATUS, 32'h04, 32'h04, RESP_OKAY);
        wr(ADDR_CTRL, 32'h01, 4'h1, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, 32'h18, RESP_OKAY);
        ev(2, 8'h0);
        ev(0, 8'h0);
        rd(ADDR_STATUS, 32'h0, 32'h18, RESP_OKAY);
        ev(2, 8'h0);
        wr(ADDR_CTRL, 32'h23, 4'h1, RESP_OKAY);
        wr(ADDR_OWN, {22'h0, own10}, 4'h3, RESP_OKAY);
        ev(0, 8'h0);
        ev(1, {TEN_HDR, own10[9:8], 1'b0});
        rd(ADDR_STATUS, 32'h02, 32'h02, RESP_OKAY);
        wr(ADDR_OWN, {22'h0, own10}, 4'h1, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, 32'h02, RESP_OKAY);
        ev(1, own10[7:0]);
        rd(ADDR_STATUS, 32'h02, 32'h02, RESP_OKAY);
        ev(2, 8'h0);
        repeat (2) @(posedge aclk);
        end_of_test();
    end
endmodule
`default_nettype wire
